// ===== tb.sv
`include "tmxirq_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rstn = 0, sel = 0, en = 0, wr = 0, pe;
	logic [11:0] addr = 12'h0;
	logic [31:0] wd = 32'h0, rd;
	wire  [31:0] prd;
	wire  [5:0]  p;
	wire         rdy, err, t2o, t2oe, irq, t2w;
	int          error_cnt = 0, checked = 0;
	initial forever #25 clk = ~clk;
	tmx_pins pm (.clk_i(clk), .oe_n_i(t2oe), .t2_o_i(t2o), .pin_o(p), .t2_o(t2w));
	tmx_irq_top dut (.REF_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(sel), .PENABLE_I(en),
		.PWRITE_I(wr), .PADDR_I(addr), .PWDATA_I(wd), .PRDATA_O(prd), .PREADY_O(rdy),
		.PSLVERR_O(err), .EXT_IRQ_ZERO_PIN_I(p[0]), .EXT_IRQ_ONE_PIN_I(p[1]),
		.COUNT_PIN_ZERO_I(p[2]), .COUNT_PIN_ONE_I(p[3]), .TIMER_TWO_CLOCK_PIN_I(t2w),
		.TIMER_TWO_CLOCK_PIN_O(t2o), .TIMER_TWO_CLOCK_PIN_OE_N_O(t2oe),
		.TIMER_TWO_AUX_CTRL_PIN_I(p[5]), .IRQ_O(irq));
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic conclude;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		sel <= 1'b1;
		wr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		en <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		rd = prd;
		pe = err;
		sel <= 1'b0;
		en <= 1'b0;
		if (n == 50) begin
			error_cnt++;
			conclude;
		end
	endtask
	task automatic put(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic get(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		check(rd, e);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		get(`TMX_ADDR_CTRL, 32'h0);
		get(`TMX_ADDR_STAT, 32'h0);
		get(12'h020, 32'h0);
		check(pe, 1'b1);
		for (int i = 0; i < 2; i++) begin
			put(`TMX_ADDR_CTRL, 32'h10 << i);
			pm.fall(i);
			get(`TMX_ADDR_STAT, 32'h1 << i);
			put(`TMX_ADDR_STAT, 32'h1 << i);
			get(`TMX_ADDR_STAT, 32'h0);
			put(`TMX_ADDR_CTRL, 32'h5 << i);
			pm.lvl(i, 1'b0);
			repeat (4) @(posedge clk);
			put(`TMX_ADDR_CNT0 + 12'(4 * i), 32'h0);
			repeat (8) @(posedge clk);
			get(`TMX_ADDR_CNT0 + 12'(4 * i), 32'h0);
			put(`TMX_ADDR_STAT, 32'h3f);
			get(`TMX_ADDR_STAT, 32'h1 << i);
			pm.lvl(i, 1'b1);
			repeat (4) @(posedge clk);
			xfer(1'b0, `TMX_ADDR_CNT0 + 12'(4 * i), 32'h0);
			check(rd != 0, 1'b1);
			put(`TMX_ADDR_STAT, 32'h3f);
			get(`TMX_ADDR_STAT, 32'h0);
			put(`TMX_ADDR_CTRL, 32'h41 << i);
			put(`TMX_ADDR_CNT0 + 12'(4 * i), 32'h0);
			repeat (3) pm.fall(2 + i);
			get(`TMX_ADDR_CNT0 + 12'(4 * i), 32'h3);
		end
		put(`TMX_ADDR_CTRL, 32'h300);
		put(`TMX_ADDR_CNT2, 32'h0);
		repeat (2) pm.fall(4);
		get(`TMX_ADDR_CNT2, 32'h2);
		put(`TMX_ADDR_RLD2, 32'hfff0);
		put(`TMX_ADDR_CNT2, 32'hfffe);
		put(`TMX_ADDR_CTRL, 32'h500);
		repeat (4) @(posedge clk);
		check(t2oe, 1'b0);
		check(t2o, 1'b1);
		get(`TMX_ADDR_STAT, 32'h10);
		// timer 2 runs on ext clock with no edges, so capture sees the written count
		put(`TMX_ADDR_CTRL, 32'h1b00);
		put(`TMX_ADDR_STAT, 32'h3f);
		check(t2oe, 1'b1);
		put(`TMX_ADDR_CNT2, 32'h1234);
		pm.fall(5);
		get(`TMX_ADDR_CAP2, 32'h1234);
		get(`TMX_ADDR_STAT, 32'h20);
		put(`TMX_ADDR_CTRL, 32'hb00);
		put(`TMX_ADDR_RLD2, 32'h55);
		pm.fall(5);
		get(`TMX_ADDR_CNT2, 32'h55);
		put(`TMX_ADDR_MASK, 32'h20);
		get(`TMX_ADDR_MASK, 32'h20);
		check(irq, 1'b1);
		put(`TMX_ADDR_MASK, 32'h0);
		get(`TMX_ADDR_STAT, 32'h20);
		check(irq, 1'b0);
		conclude;
	end
endmodule

// ===== tmx_irq_chk.sv
`include "tmxirq_map.vh"
module tmx_irq_chk (
	input wire        REF_CLK_I,
	input wire        RSTN_I,
	input wire        PSEL_I,
	input wire        PENABLE_I,
	input wire        PWRITE_I,
	input wire [11:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	input wire [31:0] PRDATA_O,
	input wire        PSLVERR_O,
	input wire        TIMER_TWO_CLOCK_PIN_O,
	input wire        TIMER_TWO_CLOCK_PIN_OE_N_O,
	input wire        IRQ_O
);
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	wire acc = PSEL_I && PENABLE_I;
	wire wctl = acc && PWRITE_I && PADDR_I == `TMX_ADDR_CTRL;
	wire okad = PADDR_I <= `TMX_ADDR_CAP2 && PADDR_I[1:0] == 2'b00;
	wire oen = TIMER_TWO_CLOCK_PIN_OE_N_O;
	sequence s_ctl(b);
		wctl && PWDATA_I[`TMX_CTRL_CLKOUT2] == b;
	endsequence
	AST_ERR_MAP: assert property (acc |-> PSLVERR_O == !okad)
		else $error("slverr wrong");
	AST_UNMAP_RD: assert property (acc && !PWRITE_I && !okad |-> PRDATA_O == 32'h0)
		else $error("unmapped read not zero");
	AST_RST: assert property ($rose(RSTN_I) |-> !IRQ_O && oen && !TIMER_TWO_CLOCK_PIN_O)
		else $error("outputs not at reset value");
	AST_OE_ON: assert property (s_ctl(1'b1) |=> !oen)
		else $error("clock pin not driven");
	AST_OE_OFF: assert property (s_ctl(1'b0) |=> oen)
		else $error("clock pin still driven");
	AST_OE_CAUSE: assert property ($changed(oen) |-> $past(wctl))
		else $error("pin enable moved without write");
	AST_PRD_HOLD: assert property ($changed(PRDATA_O) |-> $past(PSEL_I && !PENABLE_I))
		else $error("read data moved");
	AST_IRQ_OFF: assert property (acc && PWRITE_I && PADDR_I == `TMX_ADDR_MASK
		&& PWDATA_I[5:0] == 6'h00 |=> !IRQ_O)
		else $error("irq with all masked");
endmodule
bind tmx_irq_top tmx_irq_chk chk (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
	.TIMER_TWO_CLOCK_PIN_O(TIMER_TWO_CLOCK_PIN_O), .IRQ_O(IRQ_O),
	.TIMER_TWO_CLOCK_PIN_OE_N_O(TIMER_TWO_CLOCK_PIN_OE_N_O));

// ===== tmx_irq_top.v
// Contract
// - with timer 0 gate select set, the int 0 pin must be high for timer 0 to run.
// - with timer 1 gate select set, the int 1 pin must be high for timer 1 to run.
// - int 0 flag is set on a falling edge when its trigger bit is set, else on low level.
// - int 1 flag is set on a falling edge when its trigger bit is set, else on low level.
// - timer 0 in counter mode steps once per falling edge on its count pin.
// - timer 1 in counter mode steps once per falling edge on its count pin.
// - timer 2 pin is an external clock input or drives out the timer 2 generated clock.
// - timer 2 aux pin triggers reload or capture, or selects timer 2 count direction.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`include "tmxirq_map.vh"
module tmx_irq_top #(
	parameter CW = 16
) (
	input  wire        REF_CLK_I,
	input  wire        RSTN_I,
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [11:0] PADDR_I,
	input  wire [31:0] PWDATA_I,
	output reg  [31:0] PRDATA_O,
	output wire        PREADY_O,
	output wire        PSLVERR_O,
	input  wire        EXT_IRQ_ZERO_PIN_I,
	input  wire        EXT_IRQ_ONE_PIN_I,
	input  wire        COUNT_PIN_ZERO_I,
	input  wire        COUNT_PIN_ONE_I,
	input  wire        TIMER_TWO_CLOCK_PIN_I,
	output wire        TIMER_TWO_CLOCK_PIN_O,
	output wire        TIMER_TWO_CLOCK_PIN_OE_N_O,
	input  wire        TIMER_TWO_AUX_CTRL_PIN_I,
	output wire        IRQ_O
);
	localparam [CW-1:0] CNT_MAX = {CW{1'b1}};
	localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

	reg  [`TMX_CTRL_WIDTH-1:0] timer_ctrl_reg;
	reg  [`TMX_ST_WIDTH-1:0]   stat_reg;
	reg  [`TMX_ST_WIDTH-1:0]   mask_reg;
	reg  [CW-1:0]              cnt0_reg;
	reg  [CW-1:0]              cnt1_reg;
	reg  [CW-1:0]              cnt2_reg;
	reg  [CW-1:0]              rld2_reg;
	reg  [CW-1:0]              cap2_reg;
	reg                        clk2_out_reg;
	reg  [`TMX_ST_WIDTH-1:0]   stat_next;
	reg  [`TMX_ST_WIDTH-1:0]   ev_set;
	reg  [CW-1:0]              cnt0_next;
	reg  [CW-1:0]              cnt1_next;
	reg  [CW-1:0]              cnt2_next;
	wire [5:0]                 pin_lvl;
	wire [5:0]                 pin_fall;
	wire                       wr_en;
	wire                       rd_en;
	wire                       addr_ok;
	wire                       run0;
	wire                       run1;
	wire                       tick0;
	wire                       tick1;
	wire                       tick2;
	wire                       aux_ev;
	wire                       cnt2_down;

	// pin order: ext_irq_zero_pin, ext_irq_one_pin, cnt0, cnt1, t2 clock, t2 aux
	tmx_sync #(
		.W(6)
	) u_sync (
		.clk_i  (REF_CLK_I),
		.rst_n_i(RSTN_I),
		.d_i    ({TIMER_TWO_AUX_CTRL_PIN_I, TIMER_TWO_CLOCK_PIN_I, COUNT_PIN_ONE_I,
			COUNT_PIN_ZERO_I, EXT_IRQ_ONE_PIN_I, EXT_IRQ_ZERO_PIN_I}),
		.q_o    (pin_lvl),
		.fall_o (pin_fall)
	);

	function addr_hit;
		input [11:0] a;
		input [11:0] b;
		begin
			addr_hit = (a[11:2] == b[11:2]);
		end
	endfunction

	assign wr_en     = PSEL_I & PENABLE_I & PWRITE_I;
	assign rd_en     = PSEL_I & ~PENABLE_I & ~PWRITE_I;
	assign PREADY_O  = 1'b1;
	assign addr_ok   = addr_hit(PADDR_I, `TMX_ADDR_CTRL) | addr_hit(PADDR_I, `TMX_ADDR_STAT) |
		addr_hit(PADDR_I, `TMX_ADDR_MASK) | addr_hit(PADDR_I, `TMX_ADDR_CNT0) |
		addr_hit(PADDR_I, `TMX_ADDR_CNT1) | addr_hit(PADDR_I, `TMX_ADDR_CNT2) |
		addr_hit(PADDR_I, `TMX_ADDR_RLD2) | addr_hit(PADDR_I, `TMX_ADDR_CAP2);
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

	// gate: pin high lets the timer run
	assign run0 = timer_ctrl_reg[`TMX_CTRL_RUN0] &
		(~timer_ctrl_reg[`TMX_CTRL_HW_RUN_CTRL_SEL_ZERO] | pin_lvl[0]);
	assign run1 = timer_ctrl_reg[`TMX_CTRL_RUN1] &
		(~timer_ctrl_reg[`TMX_CTRL_HW_RUN_CTRL_SEL_ONE] | pin_lvl[1]);
	// timer mode counts every clock; counter mode counts pin falls only
	assign tick0 = run0 & (timer_ctrl_reg[`TMX_CTRL_CNTR0] ? pin_fall[2] : 1'b1);
	assign tick1 = run1 & (timer_ctrl_reg[`TMX_CTRL_CNTR1] ? pin_fall[3] : 1'b1);
	// external clock only while the pin is an input
	assign tick2 = timer_ctrl_reg[`TMX_CTRL_RUN2] &
		((timer_ctrl_reg[`TMX_CTRL_EXTCLK2] & ~timer_ctrl_reg[`TMX_CTRL_CLKOUT2]) ?
		pin_fall[4] : 1'b1);
	assign cnt2_down = timer_ctrl_reg[`TMX_CTRL_DIRMODE2] & ~pin_lvl[5];
	assign aux_ev = timer_ctrl_reg[`TMX_CTRL_AUXEN2] & ~timer_ctrl_reg[`TMX_CTRL_DIRMODE2] &
		pin_fall[5];

	always @* begin
		cnt0_next = cnt0_reg;
		cnt1_next = cnt1_reg;
		cnt2_next = cnt2_reg;
		ev_set    = {`TMX_ST_WIDTH{1'b0}};
		if (tick0) begin
			cnt0_next = cnt0_reg + CNT_ONE;
			ev_set[`TMX_ST_OVF0] = (cnt0_reg == CNT_MAX);
		end
		if (tick1) begin
			cnt1_next = cnt1_reg + CNT_ONE;
			ev_set[`TMX_ST_OVF1] = (cnt1_reg == CNT_MAX);
		end
		if (tick2) begin
			if (cnt2_down) begin
				cnt2_next = cnt2_reg - CNT_ONE;
				ev_set[`TMX_ST_OVF2] = (cnt2_reg == rld2_reg);
				if (cnt2_reg == rld2_reg)
					cnt2_next = CNT_MAX;
			end else if (cnt2_reg == CNT_MAX) begin
				cnt2_next = rld2_reg;
				ev_set[`TMX_ST_OVF2] = 1'b1;
			end else begin
				cnt2_next = cnt2_reg + CNT_ONE;
			end
		end
		if (aux_ev) begin
			ev_set[`TMX_ST_AUX2] = 1'b1;
			if (!timer_ctrl_reg[`TMX_CTRL_CAPMODE2])
				cnt2_next = rld2_reg;
		end
		// trigger bit set: edge, clear: level
		ev_set[`TMX_ST_IRQ0] = timer_ctrl_reg[`TMX_CTRL_TRIG0] ? pin_fall[0] : ~pin_lvl[0];
		ev_set[`TMX_ST_IRQ1] = timer_ctrl_reg[`TMX_CTRL_TRIG1] ? pin_fall[1] : ~pin_lvl[1];
		stat_next = stat_reg;
		if (wr_en && addr_hit(PADDR_I, `TMX_ADDR_STAT))
			stat_next = stat_reg & ~PWDATA_I[`TMX_ST_WIDTH-1:0];
		// set wins over a same-cycle clear
		stat_next = stat_next | ev_set;
	end

	always @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			timer_ctrl_reg <= `TMX_CTRL_RESET;
			stat_reg       <= `TMX_ST_RESET;
			mask_reg       <= `TMX_MASK_RESET;
			cnt0_reg       <= `TMX_CNT_RESET;
			cnt1_reg       <= `TMX_CNT_RESET;
			cnt2_reg       <= `TMX_CNT_RESET;
			rld2_reg       <= `TMX_CNT_RESET;
			cap2_reg       <= `TMX_CNT_RESET;
			clk2_out_reg   <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			cnt0_reg <= cnt0_next;
			cnt1_reg <= cnt1_next;
			cnt2_reg <= cnt2_next;
			if (aux_ev && timer_ctrl_reg[`TMX_CTRL_CAPMODE2])
				cap2_reg <= cnt2_reg;
			// generated clock toggles on each timer 2 overflow
			if (ev_set[`TMX_ST_OVF2])
				clk2_out_reg <= ~clk2_out_reg;
			if (wr_en) begin
				if (addr_hit(PADDR_I, `TMX_ADDR_CTRL))
					timer_ctrl_reg <= PWDATA_I[`TMX_CTRL_WIDTH-1:0];
				if (addr_hit(PADDR_I, `TMX_ADDR_MASK))
					mask_reg <= PWDATA_I[`TMX_ST_WIDTH-1:0];
				// software write beats a count in the same cycle
				if (addr_hit(PADDR_I, `TMX_ADDR_CNT0))
					cnt0_reg <= PWDATA_I[CW-1:0];
				if (addr_hit(PADDR_I, `TMX_ADDR_CNT1))
					cnt1_reg <= PWDATA_I[CW-1:0];
				if (addr_hit(PADDR_I, `TMX_ADDR_CNT2))
					cnt2_reg <= PWDATA_I[CW-1:0];
				if (addr_hit(PADDR_I, `TMX_ADDR_RLD2))
					rld2_reg <= PWDATA_I[CW-1:0];
			end
		end
	end

	// read data registered in the setup cycle, valid in access phase
	always @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			PRDATA_O <= 32'h00000000;
		end else if (rd_en) begin
			PRDATA_O <= 32'h00000000;
			if (addr_hit(PADDR_I, `TMX_ADDR_CTRL))
				PRDATA_O[`TMX_CTRL_WIDTH-1:0] <= timer_ctrl_reg;
			if (addr_hit(PADDR_I, `TMX_ADDR_STAT))
				PRDATA_O[`TMX_ST_WIDTH-1:0] <= stat_reg;
			if (addr_hit(PADDR_I, `TMX_ADDR_MASK))
				PRDATA_O[`TMX_ST_WIDTH-1:0] <= mask_reg;
			if (addr_hit(PADDR_I, `TMX_ADDR_CNT0))
				PRDATA_O[CW-1:0] <= cnt0_reg;
			if (addr_hit(PADDR_I, `TMX_ADDR_CNT1))
				PRDATA_O[CW-1:0] <= cnt1_reg;
			if (addr_hit(PADDR_I, `TMX_ADDR_CNT2))
				PRDATA_O[CW-1:0] <= cnt2_reg;
			if (addr_hit(PADDR_I, `TMX_ADDR_RLD2))
				PRDATA_O[CW-1:0] <= rld2_reg;
			if (addr_hit(PADDR_I, `TMX_ADDR_CAP2))
				PRDATA_O[CW-1:0] <= cap2_reg;
		end
	end

	assign TIMER_TWO_CLOCK_PIN_O      = clk2_out_reg;
	assign TIMER_TWO_CLOCK_PIN_OE_N_O = ~timer_ctrl_reg[`TMX_CTRL_CLKOUT2];
	assign IRQ_O = |(stat_reg & mask_reg);
endmodule

// ===== tmx_pins.sv
module tmx_pins (
	input  wire        clk_i,
	input  wire        oe_n_i,
	input  wire        t2_o_i,
	output logic [5:0] pin_o,
	output wire        t2_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin_o = 6'h3f;
	// dut drives the clock pin when enabled, else our level
	assign t2_o = oe_n_i ? pin_o[4] : t2_o_i;
	task automatic lvl(input int i, input logic v);
		@(posedge clk_i);
		pin_o[i] <= v;
	endtask
	// 3 clocks low and high, above the 1 needed between falls
	task automatic fall(input int i);
		lvl(i, 1'b0);
		repeat (3) @(posedge clk_i);
		pin_o[i] <= 1'b1;
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// ===== tmx_sync.v
module tmx_sync #(
	parameter W = 6
) (
	input  wire         clk_i,
	input  wire         rst_n_i,
	input  wire [W-1:0] d_i,
	output wire [W-1:0] q_o,
	output wire [W-1:0] fall_o
);
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : gen_bit
			// one flop set per pin, so each flop has a single driver
			reg s1_reg;
			reg s2_reg;
			reg s3_reg;
			// idle high: pins have pull-ups, so no false fall after reset
			always @(posedge clk_i) begin
				if (!rst_n_i) begin
					s1_reg <= 1'b1;
					s2_reg <= 1'b1;
					s3_reg <= 1'b1;
				end else begin
					s1_reg <= d_i[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
				end
			end
			assign q_o[g]    = s2_reg;
			assign fall_o[g] = s3_reg & ~s2_reg;
		end
	endgenerate
endmodule

// ===== tmxirq_map.vh
`ifndef TMXIRQ_MAP_VH
`define TMXIRQ_MAP_VH
`define TMX_ADDR_CTRL       12'h000
`define TMX_ADDR_STAT       12'h004
`define TMX_ADDR_MASK       12'h008
`define TMX_ADDR_CNT0       12'h00c
`define TMX_ADDR_CNT1       12'h010
`define TMX_ADDR_CNT2       12'h014
`define TMX_ADDR_RLD2       12'h018
`define TMX_ADDR_CAP2       12'h01c
`define TMX_CTRL_RUN0       0
`define TMX_CTRL_RUN1       1
`define TMX_CTRL_HW_RUN_CTRL_SEL_ZERO      2
`define TMX_CTRL_HW_RUN_CTRL_SEL_ONE      3
`define TMX_CTRL_TRIG0      4
`define TMX_CTRL_TRIG1      5
`define TMX_CTRL_CNTR0      6
`define TMX_CTRL_CNTR1      7
`define TMX_CTRL_RUN2       8
`define TMX_CTRL_EXTCLK2    9
`define TMX_CTRL_CLKOUT2    10
`define TMX_CTRL_AUXEN2     11
`define TMX_CTRL_CAPMODE2   12
`define TMX_CTRL_DIRMODE2   13
`define TMX_CTRL_WIDTH      14
`define TMX_CTRL_RESET      14'h0000
`define TMX_ST_IRQ0         0
`define TMX_ST_IRQ1         1
`define TMX_ST_OVF0         2
`define TMX_ST_OVF1         3
`define TMX_ST_OVF2         4
`define TMX_ST_AUX2         5
`define TMX_ST_WIDTH        6
`define TMX_ST_RESET        6'h00
`define TMX_MASK_RESET      6'h00
`define TMX_CNT_RESET       16'h0000
`endif
